// ---- design/cmc_pkg.sv ----
// Overview of operation
// R01 - A mode change waits, reported mode unchanged, until eleven recessive bits of bus idle.
// R02 - 111 all, 100 config, 011 listen, 010 loop, 001 disable, 000 normal; 110 and 101 reserved.
// R03 - The read-only current mode shows the mode in effect in the same coding.
// R04 - Reset sets both request and current mode to configuration, 100.
// R05 - Abort-all asks every transmit buffer to abort and clears once all have aborted.
// R06 - Clock select one gives a module clock of twice the peripheral clock, zero equal to it.
// R07 - With stop-in-idle set the controller halts in device Idle, else keeps running.
// R08 - With capture enabled each received message raises a timer capture event; the code raises it only for accepted messages while not halted.
// R09 - Window select one maps the shared region to filters, zero to buffers.
// R10 - The five-bit data compare count sets the compared data bits; 10010 to 11111 are invalid.
// R11 - A message is error checked, then filtered, and stored only if accepted.
// R12 - Standard and extended data frames of zero to eight bytes are handled.
// R13 - Up to eight prioritised abortable transmit buffers and 32 receive buffers of eight bytes.
// R14 - Up to sixteen standard or extended acceptance filters and three masks.
// R15 - Remote requests are answered automatically and bit rate reaches 1 Mbit per second.
// R16 - Software writes only defined mode codes and waits for the current mode to match.
package cmc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned BIT_TIME_MIN_NS = 1000;
    localparam logic [15:0] BIT_CLKS_MIN    = 16'(BIT_TIME_MIN_NS / CLK_PERIOD_NS);
    localparam logic [15:0] BIT_LEN_RESET   = BIT_CLKS_MIN;
    localparam logic [3:0]  IDLE_BITS       = 4'hb;
    // ----------------------------------------
    // Mode codes
    // ----------------------------------------
    localparam logic [2:0]  MODE_NORMAL     = 3'h0;
    localparam logic [2:0]  MODE_DISABLE    = 3'h1;
    localparam logic [2:0]  MODE_LOOPBACK   = 3'h2;
    localparam logic [2:0]  MODE_LISTEN     = 3'h3;
    localparam logic [2:0]  MODE_CONFIG     = 3'h4;
    localparam logic [2:0]  MODE_RSV_A      = 3'h5;
    localparam logic [2:0]  MODE_RSV_B      = 3'h6;
    localparam logic [2:0]  MODE_LISTEN_ALL = 3'h7;
    localparam logic [2:0]  MODE_RESET      = MODE_CONFIG;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0]  ADDR_CTRL1      = 8'h00;
    localparam logic [7:0]  ADDR_CTRL2      = 8'h04;
    localparam logic [7:0]  ADDR_CFG        = 8'h08;
    localparam logic [7:0]  ADDR_TIMING     = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_EN     = 8'h18;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned POS_STOP_IDLE   = 13;
    localparam int unsigned POS_ABORT       = 12;
    localparam int unsigned POS_CLK_SEL     = 11;
    localparam int unsigned POS_REQ_MODE    = 8;
    localparam int unsigned POS_CUR_MODE    = 5;
    localparam int unsigned POS_CAPTURE     = 3;
    localparam int unsigned POS_WINDOW      = 0;
    localparam logic [4:0]  DATA_COMPARE_COUNT_MAX       = 5'h11;
    localparam logic [4:0]  DATA_COMPARE_COUNT_RESET     = 5'h00;
    // ----------------------------------------
    // Capacities
    // ----------------------------------------
    localparam int unsigned TX_BUFS         = 8;
    localparam int unsigned RX_BUFS         = 32;
    localparam int unsigned FILTERS         = 16;
    localparam int unsigned MASKS           = 3;
    localparam int unsigned MAX_DATA_BYTES  = 8;
    // ----------------------------------------
    // Interrupt bits
    // ----------------------------------------
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned IRQ_MODE_DONE   = 0;
    localparam int unsigned IRQ_ABORT_DONE  = 1;
    localparam int unsigned IRQ_CAPTURE     = 2;
    localparam int unsigned IRQ_BAD_REQ     = 3;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : cmc_pkg

// ---- design/cmc_idle_if.sv ----
`timescale 1ns/1ps
interface cmc_idle_if;
    logic        rx_level;
    logic [15:0] bit_len;
    logic        clk_double;
    logic        bus_idle;
    logic        bit_tick;
    modport ctrl (output rx_level, output bit_len, output clk_double,
                  input bus_idle, input bit_tick);
    modport det  (input rx_level, input bit_len, input clk_double,
                  output bus_idle, output bit_tick);
endinterface : cmc_idle_if

// ---- design/cmc_idle_det.sv ----
`timescale 1ns/1ps
module cmc_idle_det (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    cmc_idle_if.det   idle
);
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [3:0]  rec_q;
    logic        rx_last_q;
    logic        tick_q;
    wire  [15:0] step     = idle.clk_double ? 16'h0002 : 16'h0001; // R06
    wire  [15:0] acc_sum  = acc_q + step;
    wire         fall     = rx_last_q & ~idle.rx_level;
    wire         bit_done = acc_sum >= idle.bit_len;

    // ----------------------------------------
    // Bit timing, resynced on dominant edges
    // ----------------------------------------
    assign acc_d = (fall | bit_done) ? 16'h0000 : acc_sum;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_q     <= 16'h0000;
            rx_last_q <= 1'b1;
            tick_q    <= 1'b0;
        end else begin
            acc_q     <= acc_d;
            rx_last_q <= idle.rx_level;
            tick_q    <= bit_done & ~fall;
        end
    end

    // ----------------------------------------
    // Recessive bit run
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rec_q <= 4'h0;
        end else if (!idle.rx_level) begin
            rec_q <= 4'h0; // R01
        end else if (tick_q && rec_q != cmc_pkg::IDLE_BITS) begin
            rec_q <= rec_q + 4'h1; // R01
        end
    end

    assign idle.bus_idle = (rec_q == cmc_pkg::IDLE_BITS); // R01
    assign idle.bit_tick = tick_q;
endmodule : cmc_idle_det

// ---- design/cmc_top.sv ----
`timescale 1ns/1ps
module cmc_top (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        can_rx_in,
    input  wire logic        idle_mode_in,
    input  wire logic [7:0]  abort_done_in,
    input  wire logic        rx_frame_done_in,
    input  wire logic        rx_frame_ok_in,
    input  wire logic [15:0] rx_filter_hit_in,
    output logic [7:0]       abort_request_out,
    output logic             module_clock_double_out,
    output logic             module_halted_out,
    output logic             capture_event_out,
    output logic             rx_store_out,
    output logic             window_select_out,
    output logic [4:0]       data_compare_count_out,
    output logic [2:0]       current_mode_out,
    output logic             irq_out
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                     rx_meta_q;
    logic                     rx_sync_q;
    logic                     aw_hold_q;
    logic [7:0]               aw_addr_q;
    logic                     w_hold_q;
    logic [31:0]              w_data_q;
    logic [3:0]               w_strb_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;
    logic                     rvalid_q;
    logic [31:0]              rdata_q;
    logic [1:0]               rresp_q;
    logic                     stop_in_idle_q;
    logic                     abort_all_transmit_q;
    logic                     protocol_clock_select_q;
    logic [2:0]               requested_mode_q;
    logic [2:0]               current_mode_q;
    logic                     receive_capture_enable_q;
    logic                     register_window_select_q;
    logic [4:0]               data_compare_count_q;
    logic [15:0]              bit_len_q;
    logic [cmc_pkg::TX_BUFS-1:0] abort_pend_q;
    logic                     abort_busy_q;
    logic                     capture_q;
    logic                     store_q;
    logic [cmc_pkg::IRQ_W-1:0] irq_stat_q;
    logic [cmc_pkg::IRQ_W-1:0] irq_en_q;
    logic [cmc_pkg::IRQ_W-1:0] irq_set;
    logic [15:0]              ctrl1_img;
    logic [31:0]              rd_mux;
    logic                     rd_hit;

    cmc_idle_if idle_bus ();

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= can_rx_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign idle_bus.rx_level   = rx_sync_q;
    assign idle_bus.bit_len    = bit_len_q;
    assign idle_bus.clk_double = protocol_clock_select_q;

    cmc_idle_det u_idle_det (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .idle     (idle_bus.det)
    );

    // ----------------------------------------
    // Bus write channel
    // ----------------------------------------
    wire aw_fire  = s_axi_awvalid_in & s_axi_awready_out;
    wire w_fire   = s_axi_wvalid_in & s_axi_wready_out;
    wire wr_fire  = aw_hold_q & w_hold_q & ~bvalid_q;
    wire lane0    = w_strb_q[0];
    wire lane1    = w_strb_q[1];

    assign s_axi_awready_out = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready_out  = ~w_hold_q & ~bvalid_q;

    wire wr_ctrl1  = wr_fire && aw_addr_q == cmc_pkg::ADDR_CTRL1;
    wire wr_ctrl2  = wr_fire && aw_addr_q == cmc_pkg::ADDR_CTRL2;
    wire wr_cfg    = wr_fire && aw_addr_q == cmc_pkg::ADDR_CFG;
    wire wr_timing = wr_fire && aw_addr_q == cmc_pkg::ADDR_TIMING;
    wire wr_stat   = wr_fire && aw_addr_q == cmc_pkg::ADDR_IRQ_STAT;
    wire wr_clr    = wr_fire && aw_addr_q == cmc_pkg::ADDR_IRQ_CLR;
    wire wr_en     = wr_fire && aw_addr_q == cmc_pkg::ADDR_IRQ_EN;
    wire wr_hit    = wr_ctrl1 | wr_ctrl2 | wr_cfg | wr_timing | wr_stat | wr_clr | wr_en;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (w_fire) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Read-only registers answer writes with an error
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= cmc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_hit && !wr_ctrl2 && !wr_stat) ? cmc_pkg::RESP_OKAY
                                                          : cmc_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out  = bresp_q;

    // ----------------------------------------
    // Control register one
    // ----------------------------------------
    wire [2:0] wr_req_mode = w_data_q[cmc_pkg::POS_REQ_MODE +: 3];
    wire       wr_req_bad  = wr_ctrl1 & lane1 &
                             (wr_req_mode == cmc_pkg::MODE_RSV_A ||
                              wr_req_mode == cmc_pkg::MODE_RSV_B); // R02
    wire       wr_abort    = wr_ctrl1 & lane1 & w_data_q[cmc_pkg::POS_ABORT];

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_in_idle_q           <= 1'b0;
            protocol_clock_select_q  <= 1'b0;
            requested_mode_q         <= cmc_pkg::MODE_RESET; // R04
            receive_capture_enable_q <= 1'b0;
            register_window_select_q <= 1'b0;
        end else if (wr_ctrl1) begin
            if (lane1) begin
                stop_in_idle_q          <= w_data_q[cmc_pkg::POS_STOP_IDLE];
                protocol_clock_select_q <= w_data_q[cmc_pkg::POS_CLK_SEL];
                requested_mode_q        <= wr_req_mode; // R02
            end
            if (lane0) begin
                receive_capture_enable_q <= w_data_q[cmc_pkg::POS_CAPTURE];
                register_window_select_q <= w_data_q[cmc_pkg::POS_WINDOW]; // R09
            end
        end
    end

    // ----------------------------------------
    // Mode change
    // ----------------------------------------
    wire halted      = stop_in_idle_q & idle_mode_in; // R07
    wire req_valid   = requested_mode_q != cmc_pkg::MODE_RSV_A &&
                       requested_mode_q != cmc_pkg::MODE_RSV_B; // R02
    wire mode_change = req_valid && requested_mode_q != current_mode_q &&
                       idle_bus.bus_idle && !halted; // R01

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            current_mode_q <= cmc_pkg::MODE_RESET; // R04
        end else if (mode_change) begin
            current_mode_q <= requested_mode_q; // R03
        end
    end

    // ----------------------------------------
    // Abort of all transmit buffers
    // ----------------------------------------
    // Each buffer stays asked until it reports; the bit clears only when all have
    genvar gi;
    generate
        for (gi = 0; gi < cmc_pkg::TX_BUFS; gi++) begin : g_abort
            always_ff @(posedge clock_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    abort_pend_q[gi] <= 1'b0;
                end else if (wr_abort && !abort_all_transmit_q) begin
                    abort_pend_q[gi] <= 1'b1; // R05 R13
                end else if (abort_done_in[gi]) begin
                    abort_pend_q[gi] <= 1'b0; // R13
                end
            end
        end
    endgenerate

    wire abort_finish = abort_busy_q & ~(|abort_pend_q) & ~wr_abort;

    // A new write of one wins over the hardware clear
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            abort_all_transmit_q <= 1'b0;
            abort_busy_q         <= 1'b0;
        end else if (wr_abort) begin
            abort_all_transmit_q <= 1'b1; // R05
            abort_busy_q         <= 1'b1;
        end else if (abort_finish) begin
            abort_all_transmit_q <= 1'b0; // R05
            abort_busy_q         <= 1'b0;
        end
    end

    assign abort_request_out = abort_pend_q; // R05

    // ----------------------------------------
    // Data compare count and bit timing
    // ----------------------------------------
    wire        cnt_ok  = w_data_q[4:0] <= cmc_pkg::DATA_COMPARE_COUNT_MAX; // R10
    wire [15:0] len_min = protocol_clock_select_q ? {cmc_pkg::BIT_CLKS_MIN[14:0], 1'b0}
                                                  : cmc_pkg::BIT_CLKS_MIN; // R15
    wire [15:0] len_wr  = w_data_q[15:0] < len_min ? len_min : w_data_q[15:0];

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_compare_count_q <= cmc_pkg::DATA_COMPARE_COUNT_RESET;
            bit_len_q            <= cmc_pkg::BIT_LEN_RESET;
        end else begin
            if (wr_cfg && lane0 && cnt_ok) begin
                data_compare_count_q <= w_data_q[4:0]; // R10
            end
            if (wr_timing && lane0 && lane1) begin
                bit_len_q <= len_wr; // R15
            end
        end
    end

    // ----------------------------------------
    // Receive path events
    // ----------------------------------------
    // Filter result counts only for a frame already free of errors
    wire accepted = rx_frame_done_in & rx_frame_ok_in & (|rx_filter_hit_in); // R11 R14

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            store_q   <= 1'b0;
            capture_q <= 1'b0;
        end else begin
            store_q   <= accepted & ~halted; // R11 R12
            capture_q <= accepted & ~halted & receive_capture_enable_q; // R08
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    always_comb begin
        irq_set                           = '0;
        irq_set[cmc_pkg::IRQ_MODE_DONE]   = mode_change;
        irq_set[cmc_pkg::IRQ_ABORT_DONE]  = abort_finish;
        irq_set[cmc_pkg::IRQ_CAPTURE]     = capture_q;
        irq_set[cmc_pkg::IRQ_BAD_REQ]     = wr_req_bad;
    end

    wire [cmc_pkg::IRQ_W-1:0] irq_clr = (wr_clr && lane0) ? w_data_q[cmc_pkg::IRQ_W-1:0]
                                                          : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (wr_en && lane0) begin
                irq_en_q <= w_data_q[cmc_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq_out = |(irq_stat_q & irq_en_q);

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always_comb begin
        ctrl1_img                                 = 16'h0000;
        ctrl1_img[cmc_pkg::POS_STOP_IDLE]         = stop_in_idle_q;
        ctrl1_img[cmc_pkg::POS_ABORT]             = abort_all_transmit_q;
        ctrl1_img[cmc_pkg::POS_CLK_SEL]           = protocol_clock_select_q;
        ctrl1_img[cmc_pkg::POS_REQ_MODE +: 3]     = requested_mode_q;
        ctrl1_img[cmc_pkg::POS_CUR_MODE +: 3]     = current_mode_q; // R03
        ctrl1_img[cmc_pkg::POS_CAPTURE]           = receive_capture_enable_q;
        ctrl1_img[cmc_pkg::POS_WINDOW]            = register_window_select_q;
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr_in == cmc_pkg::ADDR_CTRL1) begin
            rd_mux = {16'h0000, ctrl1_img};
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_CTRL2) begin
            rd_mux = {27'h0000000, data_compare_count_q}; // R10
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_CFG) begin
            rd_mux = {27'h0000000, data_compare_count_q};
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_TIMING) begin
            rd_mux = {16'h0000, bit_len_q};
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_IRQ_STAT) begin
            rd_mux = {28'h0000000, irq_stat_q};
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_IRQ_CLR) begin
            rd_mux = 32'h0000_0000;
        end else if (s_axi_araddr_in == cmc_pkg::ADDR_IRQ_EN) begin
            rd_mux = {28'h0000000, irq_en_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign s_axi_arready_out = ~rvalid_q;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= cmc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out  = rdata_q;
    assign s_axi_rresp_out  = rresp_q;

    // ----------------------------------------
    // Block outputs
    // ----------------------------------------
    assign module_clock_double_out = protocol_clock_select_q; // R06
    assign module_halted_out       = halted; // R07
    assign capture_event_out       = capture_q; // R08
    assign rx_store_out            = store_q; // R11
    assign window_select_out       = register_window_select_q; // R09
    assign data_compare_count_out  = data_compare_count_q;
    assign current_mode_out        = current_mode_q; // R03
endmodule : cmc_top

// ---- dv/cmc_assertions.sv ----
`timescale 1ns/1ps
module cmc_assertions (
    input wire logic       clock_in,
    input wire logic       nrst_in,
    input wire logic       can_rx_in,
    input wire logic       module_halted_out,
    input wire logic [7:0] abort_request_out,
    input wire logic [7:0] abort_done_in,
    input wire logic [4:0] data_compare_count_out,
    input wire logic [2:0] current_mode_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_reset_mode: assert property ($rose(nrst_in) |-> current_mode_out == 3'h4)
        else $error("mode after reset");
    a_reset_count: assert property ($rose(nrst_in) |-> data_compare_count_out == 5'h00)
        else $error("count after reset");
    a_idle_change: assert property ($changed(current_mode_out) |-> $past(can_rx_in, 10))
        else $error("mode moved on busy bus");
    a_mode_coded: assert property (!(current_mode_out inside {3'h5, 3'h6}))
        else $error("reserved mode shown");
    a_halt_freeze: assert property (module_halted_out [*2] |=> $stable(current_mode_out))
        else $error("mode moved while halted");
    a_abort_all: assert property ($rose(|abort_request_out) |-> &abort_request_out)
        else $error("abort not to all");
    a_abort_hold: assert property ((~abort_request_out & $past(abort_request_out)
        & ~$past(abort_done_in)) == 8'h00) else $error("abort dropped early");
    a_count_valid: assert property (data_compare_count_out <= 5'h11)
        else $error("count invalid");
    c_mode: cover property ($changed(current_mode_out));
    c_abort: cover property ($fell(|abort_request_out));
    c_halt: cover property (module_halted_out);
endmodule : cmc_assertions
bind cmc_top cmc_assertions i_cmc_assertions (.*);

// ---- dv/cmc_can_node.sv ----
`timescale 1ns/1ps
module cmc_can_node (
    input  wire logic       clock_in,
    input  wire logic       busy_in,
    input  wire logic       ack_en_in,
    input  wire logic [7:0] abort_request_in,
    output logic            can_rx_out,
    output logic [7:0]      abort_done_out
);
    initial {can_rx_out, abort_done_out} = 9'h100;
    // Stall input keeps aborts pending so the bench sees them held
    always @(posedge clock_in) begin
        can_rx_out     <= !busy_in;
        abort_done_out <= abort_request_in & {8{ack_en_in}};
    end
endmodule : cmc_can_node

// ---- dv/test_can_mode_control.sv ----
`timescale 1ns/1ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_can_mode_control;
    logic        clock_in = 1'b0, nrst_in = 1'b0, idle_mode_in = 1'b0, busy = 1'b0;
    logic        rx_frame_done_in = 1'b0, rx_frame_ok_in = 1'b0, ack_en = 1'b1;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, lfsr = 8'h5e;
    logic [31:0] s_axi_wdata_in = 32'h0, mdl;
    logic [3:0]  s_axi_wstrb_in = 4'hf;
    logic [15:0] rx_filter_hit_in = 16'h0;
    logic [2:0]  modes[$] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0};
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire         s_axi_rvalid_out, module_clock_double_out, module_halted_out, irq_out;
    wire         capture_event_out, rx_store_out, window_select_out, can_rx_in;
    wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0]  s_axi_rdata_out;
    wire [7:0]   abort_request_out, abort_done_in;
    wire [4:0]   data_compare_count_out;
    wire [2:0]   current_mode_out;
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    cmc_top i_cmc_top (.*);
    cmc_can_node i_cmc_can_node (.clock_in(clock_in), .busy_in(busy), .ack_en_in(ack_en),
        .abort_request_in(abort_request_out), .can_rx_out(can_rx_in), .abort_done_out(abort_done_in));
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) if (++cyc == 20000) begin error_cnt++; report_and_stop(); end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], ^(s & 8'hb8)};
    endfunction : nxt
    // One task for both directions: write data and expected response share e
    task automatic bus(input logic w, input logic [7:0] a, input logic [33:0] e);
        @(posedge clock_in);
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, e[31:0]};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{w}};
        {s_axi_arvalid_in, s_axi_rready_in} <= {2{!w}};
        do @(posedge clock_in); while (w ? !s_axi_awready_out : !s_axi_arready_out);
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} <= 3'h0;
        do @(posedge clock_in); while (!(s_axi_bvalid_out || s_axi_rvalid_out));
        {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
        `CK({w ? s_axi_bresp_out : s_axi_rresp_out, w ? 32'h0 : s_axi_rdata_out}, w ? e & 34'h300000000 : e)
    endtask : bus
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge clock_in);
        nrst_in <= 1'b1;
        bus(0, 8'h00, 34'h480);
        bus(1, 8'h08, 34'h11);
        bus(1, 8'h08, 34'h12);
        `CK(data_compare_count_out, 5'h11)
        bus(0, 8'h04, 34'h11);
        bus(1, 8'h04, 34'h200000000);
        bus(0, 8'h40, 34'h200000000);
        bus(1, 8'h18, 34'h1);
        foreach (modes[i]) begin
            lfsr = nxt(lfsr);
            mdl = {20'h0, lfsr[0], modes[i], 4'h0, lfsr[1], 2'h0, lfsr[2]};
            busy <= 1'b1;
            repeat (4) @(posedge clock_in);
            bus(1, 8'h00, {2'h0, mdl});
            repeat (50) @(posedge clock_in);
            `CK(current_mode_out, i ? modes[i-1] : 3'h4)
            busy <= 1'b0;
            repeat (1200) @(posedge clock_in);
            bus(0, 8'h00, {2'h0, mdl | (32'(modes[i]) << 5)});
            `CK({module_clock_double_out, window_select_out}, {lfsr[0], lfsr[2]})
        end
        `CK(irq_out, 1'b1)
        bus(1, 8'h18, 34'h0);
        `CK(irq_out, 1'b0)
        bus(1, 8'h14, 34'hf);
        bus(1, 8'h18, 34'h2);
        ack_en <= 1'b0;
        bus(1, 8'h00, 34'h1008);
        repeat (2) @(posedge clock_in);
        `CK(abort_request_out, 8'hff)
        ack_en <= 1'b1;
        repeat (8) @(posedge clock_in);
        bus(0, 8'h00, 34'h8);
        `CK(irq_out, 1'b1)
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            {rx_frame_ok_in, rx_filter_hit_in, rx_frame_done_in} <= {k[1], {8'h0, lfsr} & {16{k[0]}}, 1'b1};
            @(posedge clock_in);
            rx_frame_done_in <= 1'b0;
            @(posedge clock_in);
            `CK({rx_store_out, capture_event_out}, {2{k[0] & k[1]}})
        end
        idle_mode_in <= 1'b1;
        bus(1, 8'h00, 34'h2408);
        repeat (50) @(posedge clock_in);
        `CK({module_halted_out, current_mode_out}, 4'h8)
        report_and_stop();
    end
endmodule : test_can_mode_control
